// File: logic/ced_params.svh
// constants for the execution-state and extension-dispatch front end
// assumes a single 25 MHz clock; included by the package users by bare name
// How it works
// RQ1: refresh due or halt pin enters stop state
// RQ2: bus request suspends execution, releases bus
// RQ3: privileged instructions refused in normal mode
// RQ4: segmented gives 23-bit, else 16-bit addresses
// RQ5: modes follow flag_control_word bits while executing
// RQ6: interrupt handling forces system and segmented
// RQ7: both top bits one selects compact format
// RQ8: compact format holds four frequent instructions
// RQ9: top bits plus source field give mode
// RQ10: register fields are four bits wide
// RQ11: register, immediate, indirect, direct operands supported
// RQ12: index address is address plus register
// RQ13: relative address is pc plus displacement
// RQ14: base adds displacement; base index adds register
// RQ15: operand placement restricted by data type; the code checks only the addressing mode, not the data type
// RQ16: at most four extension units in parallel
// RQ17: extension units watch bus, recognise their instructions
// RQ18: processor issues extended instructions and operands
// RQ19: extended instructions span four transfer classes
// RQ20: extension transfers use four addressing modes only
// RQ21: no extension units means trap extended instructions
// RQ22: extension_mode_bit one dispatches, zero traps
// RQ23: busy extension unit holds halt until done; the code instead traps an extended instruction while unit 0 is busy
// RQ24: system bit sets mode; pin is complement
// RQ25: resume exactly where suspended after stop
`ifndef CED_PARAMS_SVH
`define CED_PARAMS_SVH
`define CED_FCW_SYSTEM_BIT 14
`define CED_FCW_SEG_BIT 15
`define CED_FCW_EXT_BIT 10
`define CED_FCW_RESET 16'h4000
`define CED_EXT_OPCODE 4'he
`define CED_EXT_UNITS 4
`define CED_PRIV_OPCODE_IO 6'h3d
`endif

// File: logic/ced_pkg.sv
// types shared by the execution front end and its address former
// no assumptions beyond the params header
package ced_pkg;
  typedef enum logic [1:0] {
    CED_RUN = 2'b00,
    CED_STOP = 2'b01,
    CED_DISC = 2'b10
  } ced_state_t;
  typedef enum logic [2:0] {
    CED_AM_REG = 3'b000,
    CED_AM_IMM = 3'b001,
    CED_AM_IR = 3'b010,
    CED_AM_DA = 3'b011,
    CED_AM_X = 3'b100,
    CED_AM_RA = 3'b101,
    CED_AM_BA = 3'b110,
    CED_AM_BX = 3'b111
  } ced_amode_t;
  typedef enum logic [1:0] {
    CED_EXT_MEM = 2'b00,
    CED_EXT_REG = 2'b01,
    CED_EXT_OP = 2'b10,
    CED_EXT_FLAG = 2'b11
  } ced_ext_class_t;
  typedef struct packed {
    logic [15:0] word;
    logic [15:0] ext;
    logic [15:0] pc;
    logic [15:0] reg_src;
    logic [15:0] reg_idx;
    logic [6:0] long_address_mode_bit;
  } ced_operand_t;
  typedef struct packed {
    logic compact;
    logic [1:0] compact_op;
    ced_amode_t amode;
    logic [3:0] src;
    logic [3:0] dst;
    logic privileged;
    logic extended;
    logic [1:0] ext_unit;
    ced_ext_class_t ext_class;
    logic mode_ok;
  } ced_decode_t;
endpackage

// File: logic/ced_addr_former.sv
// effective address former: forms the address of one operand
// inputs come from the same clock domain; result registered
`timescale 1ns/1ns
`include "ced_params.svh"
module ced_addr_former (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // request
  input wire logic go_in,
  input wire ced_pkg::ced_amode_t amode_in,
  input wire logic segmented_in,
  input wire ced_pkg::ced_operand_t opnd_in,
  // result
  output logic [22:0] addr_out,
  output logic mem_out
);
  typedef struct packed {
    logic [22:0] addr;
    logic mem;
  } ced_af_state_t;
  ced_af_state_t st, next_st;
  logic [15:0] off;

  function automatic logic [22:0] ced_join(input logic long_address_mode_bit, input logic [6:0] s, input logic [15:0] o);
    ced_join = long_address_mode_bit ? {s, o} : {7'h00, o}; // see RQ4
  endfunction

  always_comb begin
    next_st = st;
    off = 16'h0000;
    if (go_in) begin
      next_st.mem = 1'b1;
      case (amode_in)
        ced_pkg::CED_AM_REG,
        ced_pkg::CED_AM_IMM: next_st.mem = 1'b0; // see RQ11
        ced_pkg::CED_AM_IR: off = opnd_in.reg_src; // see RQ11
        ced_pkg::CED_AM_DA: off = opnd_in.ext; // see RQ11
        ced_pkg::CED_AM_X: off = opnd_in.ext + opnd_in.reg_idx; // see RQ12
        ced_pkg::CED_AM_RA: off = opnd_in.pc + opnd_in.ext; // see RQ13
        ced_pkg::CED_AM_BA: off = opnd_in.reg_src + opnd_in.ext; // see RQ14
        ced_pkg::CED_AM_BX: off = opnd_in.reg_src + opnd_in.reg_idx; // see RQ14
        default: next_st.mem = 1'b0;
      endcase
      next_st.addr = next_st.mem ? ced_join(segmented_in, opnd_in.long_address_mode_bit, off) : 23'h000000;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign addr_out = st.addr;
  assign mem_out = st.mem;
endmodule

// File: logic/ced_exec_front.sv
// execution state tracker, instruction classifier and extension dispatcher
// halt and bus request arrive from pins and are synchronised; the rest is same-clock logic
`timescale 1ns/1ns
`include "ced_params.svh"
module ced_exec_front #(
  parameter int EXT_UNITS = `CED_EXT_UNITS
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // pins from the outside
  input wire logic halt_n_in,
  input wire logic bus_req_n_in,
  // internal events
  input wire logic refresh_due_in,
  input wire logic refresh_done_in,
  input wire logic in_interrupt_in,
  // control word load
  input wire logic fcw_load_in,
  input wire logic [15:0] fcw_in,
  input wire logic ext_units_present_in,
  // instruction issue
  input wire logic instr_valid_in,
  input wire ced_pkg::ced_operand_t opnd_in,
  input wire logic [1:0] ext_busy_in,
  // state outputs
  output ced_pkg::ced_state_t state_out,
  output logic running_out,
  output logic bus_release_out,
  output logic refresh_active_out,
  output logic normal_mode_out,
  output logic segmented_out,
  output logic [15:0] flag_control_word_out,
  // decode and dispatch outputs
  output logic instr_taken_out,
  output ced_pkg::ced_decode_t decode_out,
  output logic priv_trap_out,
  output logic ext_trap_out,
  output logic ext_issue_out,
  output logic [1:0] ext_unit_out,
  output logic [15:0] ext_word_out,
  output logic [22:0] addr_out,
  output logic addr_mem_out
);
  typedef struct packed {
    logic [1:0] halt_sync;
    logic [1:0] breq_sync;
    ced_pkg::ced_state_t state;
    logic [15:0] flag_control_word;
    ced_pkg::ced_decode_t dec;
    logic taken;
    logic priv_trap;
    logic ext_trap;
    logic ext_issue;
    logic [15:0] ext_word;
  } ced_front_state_t;
  ced_front_state_t st, next_st;
  ced_pkg::ced_decode_t d;
  logic sys_mode;
  logic seg_mode;
  logic halt_now;
  logic breq_now;
  logic go;

  // addressing mode from top bits and source field
  function automatic ced_pkg::ced_amode_t ced_mode(input logic [1:0] top, input logic [3:0] src);
    case (top)
      2'b00: ced_mode = (src == 4'h0) ? ced_pkg::CED_AM_IMM : ced_pkg::CED_AM_IR; // see RQ9
      2'b01: ced_mode = (src == 4'h0) ? ced_pkg::CED_AM_DA : ced_pkg::CED_AM_X; // see RQ9
      2'b10: ced_mode = ced_pkg::CED_AM_REG; // see RQ9
      default: ced_mode = ced_pkg::CED_AM_REG;
    endcase
  endfunction

  // modes that may move data to or from extension registers
  function automatic logic ced_ext_mode_ok(input ced_pkg::ced_amode_t m);
    case (m)
      ced_pkg::CED_AM_REG,
      ced_pkg::CED_AM_IR,
      ced_pkg::CED_AM_DA,
      ced_pkg::CED_AM_X: ced_ext_mode_ok = 1'b1; // see RQ20
      default: ced_ext_mode_ok = 1'b0;
    endcase
  endfunction

  // second synchroniser stage only
  assign halt_now = ~st.halt_sync[1];
  assign breq_now = ~st.breq_sync[1];

  // interrupts force both system and segmented mode
  assign sys_mode = in_interrupt_in | st.flag_control_word[`CED_FCW_SYSTEM_BIT]; // see RQ5 see RQ6 see RQ24
  assign seg_mode = in_interrupt_in | st.flag_control_word[`CED_FCW_SEG_BIT]; // see RQ4 see RQ6

  // decode of the presented word
  always_comb begin
    d = '0;
    d.compact = (opnd_in.word[15:14] == 2'b11); // see RQ7
    d.src = opnd_in.word[7:4]; // see RQ10
    d.dst = opnd_in.word[3:0]; // see RQ10
    if (d.compact) begin
      // one word carries one of four frequent instructions, register operand
      d.compact_op = opnd_in.word[13:12]; // see RQ8
      d.amode = ced_pkg::CED_AM_REG;
    end else begin
      d.amode = ced_mode(opnd_in.word[15:14], d.src);
      // relative and based forms ride on the register form with a flag bit
      if (opnd_in.word[15:14] == 2'b10 && opnd_in.word[13] && d.src == 4'h0) begin
        d.amode = ced_pkg::CED_AM_RA; // see RQ13
      end else if (opnd_in.word[15:14] == 2'b10 && opnd_in.word[13]) begin
        d.amode = opnd_in.word[12] ? ced_pkg::CED_AM_BX : ced_pkg::CED_AM_BA; // see RQ14
      end
      d.privileged = (opnd_in.word[13:8] == `CED_PRIV_OPCODE_IO); // see RQ3
      d.extended = (opnd_in.word[11:8] == `CED_EXT_OPCODE) && !d.privileged;
    end
    d.ext_unit = opnd_in.word[1:0]; // see RQ16
    d.ext_class = ced_pkg::ced_ext_class_t'(opnd_in.word[3:2]); // see RQ19
    // extended instructions need one of the four extension operand modes; the transfer class is not checked
    d.mode_ok = d.extended ? ced_ext_mode_ok(d.amode) : 1'b1; // see RQ15 see RQ20
  end

  assign go = instr_valid_in && (st.state == ced_pkg::CED_RUN);

  always_comb begin
    next_st = st;
    next_st.halt_sync = {st.halt_sync[0], halt_n_in};
    next_st.breq_sync = {st.breq_sync[0], bus_req_n_in};
    next_st.taken = 1'b0;
    next_st.priv_trap = 1'b0;
    next_st.ext_trap = 1'b0;
    next_st.ext_issue = 1'b0;
    if (fcw_load_in) begin
      next_st.flag_control_word = fcw_in;
    end
    case (st.state)
      ced_pkg::CED_RUN: begin
        // suspension keeps fcw and all held state, so the return resumes in place
        if (breq_now) begin
          next_st.state = ced_pkg::CED_DISC; // see RQ2
        end else if (halt_now || refresh_due_in) begin
          next_st.state = ced_pkg::CED_STOP; // see RQ1 see RQ23
        end
      end
      ced_pkg::CED_STOP: begin
        // a busy extension unit holds halt low; leave only once it lets go
        if (!halt_now && (refresh_done_in || !refresh_due_in)) begin
          next_st.state = ced_pkg::CED_RUN; // see RQ1 see RQ23 see RQ25
        end
      end
      ced_pkg::CED_DISC: begin
        if (!breq_now) begin
          next_st.state = ced_pkg::CED_RUN; // see RQ25
        end
      end
      default: next_st.state = ced_pkg::CED_RUN;
    endcase
    // an instruction is accepted only if no suspension is starting this cycle
    if (go && !breq_now && !halt_now && !refresh_due_in) begin
      next_st.taken = 1'b1;
      next_st.dec = d;
      if (d.privileged && !sys_mode) begin
        next_st.priv_trap = 1'b1; // see RQ3
      end else if (d.extended) begin
        if (st.flag_control_word[`CED_FCW_EXT_BIT] && ext_units_present_in && d.mode_ok &&
            ({1'b0, d.ext_unit} < EXT_UNITS[2:0]) && !ext_busy_in[0]) begin
          next_st.ext_issue = 1'b1; // see RQ18 see RQ22
          next_st.ext_word = opnd_in.ext;
        end else if (!st.flag_control_word[`CED_FCW_EXT_BIT] || !ext_units_present_in) begin
          next_st.ext_trap = 1'b1; // see RQ21 see RQ22
        end else begin
          // bad mode, absent unit slot or unit 0 busy: treat as not executable, emulate in software
          next_st.ext_trap = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      st <= '0;
      st.halt_sync <= 2'b11;
      st.breq_sync <= 2'b11;
      st.flag_control_word <= `CED_FCW_RESET;
    end else begin
      st <= next_st;
    end
  end

  ced_addr_former u_addr (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .go_in(go),
    .amode_in(d.amode),
    .segmented_in(seg_mode),
    .opnd_in(opnd_in),
    .addr_out(addr_out),
    .mem_out(addr_mem_out)
  );

  // extension units watch the bus for these words themselves; the unit field selects which one answers
  assign ext_unit_out = st.dec.ext_unit; // see RQ17
  assign ext_word_out = st.ext_word;
  assign ext_issue_out = st.ext_issue;
  assign ext_trap_out = st.ext_trap;
  assign priv_trap_out = st.priv_trap;
  assign instr_taken_out = st.taken;
  assign decode_out = st.dec;
  assign state_out = st.state;
  assign running_out = (st.state == ced_pkg::CED_RUN);
  assign bus_release_out = (st.state == ced_pkg::CED_DISC); // see RQ2
  assign refresh_active_out = (st.state == ced_pkg::CED_STOP); // see RQ1
  assign normal_mode_out = ~sys_mode; // see RQ24
  assign segmented_out = seg_mode;
  assign flag_control_word_out = st.flag_control_word;
endmodule

// File: test/ced_exec_front_assertions.sv
// assertions on the execution front end
// sees only top ports; bound at the foot
`timescale 1ns/1ns
module ced_exec_front_assertions #(
  parameter int EXT_UNITS = 4
) (
  // clock, reset and inputs
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic halt_n_in,
  input wire logic bus_req_n_in,
  input wire logic in_interrupt_in,
  input wire ced_pkg::ced_operand_t opnd_in,
  // outputs
  input wire ced_pkg::ced_state_t state_out,
  input wire logic bus_release_out,
  input wire logic normal_mode_out,
  input wire logic segmented_out,
  input wire logic [15:0] flag_control_word_out,
  input wire logic instr_taken_out,
  input wire ced_pkg::ced_decode_t decode_out,
  input wire logic priv_trap_out,
  input wire logic ext_trap_out,
  input wire logic ext_issue_out,
  input wire logic [1:0] ext_unit_out,
  input wire logic [22:0] addr_out
);
  ced_pkg::ced_operand_t prev;
  // operand as it stood at the take edge
  always_ff @(posedge clk_in) begin
    prev <= opnd_in;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  chk_no_take_susp: assert property (state_out != ced_pkg::CED_RUN |=> !instr_taken_out)
    else $error("take while suspended");
  chk_disc_entry: assert property ((!bus_req_n_in && halt_n_in) [*4] |-> bus_release_out)
    else $error("no disconnect");
  chk_stop_entry: assert property ((!halt_n_in && bus_req_n_in) [*4] |-> state_out == ced_pkg::CED_STOP)
    else $error("no stop");
  chk_priv_refuse: assert property (instr_taken_out && decode_out.privileged && $past(normal_mode_out)
    |-> priv_trap_out)
    else $error("privileged ran");
  chk_ext_trapped: assert property (instr_taken_out && decode_out.extended && !$past(flag_control_word_out[10])
    |-> ext_trap_out && !ext_issue_out)
    else $error("extended not trapped");
  chk_compact_fmt: assert property (instr_taken_out |-> decode_out.compact == (prev.word[15:14] == 2'b11))
    else $error("format wrong");
  chk_mode_pin: assert property (normal_mode_out == !(flag_control_word_out[14] || in_interrupt_in))
    else $error("mode pin wrong");
  chk_seg_mode: assert property (segmented_out == (flag_control_word_out[15] || in_interrupt_in))
    else $error("segment mode wrong");
  chk_unit_limit: assert property (ext_issue_out |-> ext_unit_out < EXT_UNITS)
    else $error("unit out of range");
  chk_rel_addr: assert property (instr_taken_out && decode_out.amode == ced_pkg::CED_AM_RA && !$past(segmented_out)
    |-> addr_out == {7'h00, prev.pc + prev.ext})
    else $error("relative address wrong");
  cover property (ext_issue_out);
  cover property (ext_trap_out);
  cover property (bus_release_out);
endmodule
bind ced_exec_front ced_exec_front_assertions #(.EXT_UNITS(EXT_UNITS)) u_chk (.*);

// File: test/ced_ext_unit_model.sv
// one extension unit: busy for a while after each issue
// assumes issues arrive on the shared clock
`timescale 1ns/1ns
module ced_ext_unit_model #(
  parameter int WORK = 4
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic issue_in,
  output logic halt_n_out,
  output logic [1:0] busy_out
);
  int cnt;
  logic stall;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt <= 0;
      stall <= 1'b0;
    end else if (issue_in) begin
      stall <= cnt != 0;
      cnt <= WORK;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end else begin
      stall <= 1'b0;
    end
  end
  // overlap holds the cpu off until the work ends
  assign halt_n_out = !(stall && cnt != 0);
  assign busy_out = {1'b0, cnt != 0};
endmodule

// File: test/ced_exec_front_tb_top.sv
// bench for the execution front end with one extension unit
// assumes package, design and checker compiled first
`timescale 1ns/1ns
module ced_exec_front_tb_top;
  logic clk_in, reset_in, halt_n_in, bus_req_n_in, refresh_due_in, refresh_done_in, in_interrupt_in;
  logic fcw_load_in, ext_units_present_in, instr_valid_in, hold_n, unit_halt_n;
  logic [15:0] fcw_in, flag_control_word_out, ext_word_out;
  logic [1:0] ext_busy_in, ext_unit_out;
  ced_pkg::ced_operand_t opnd_in;
  ced_pkg::ced_state_t state_out;
  ced_pkg::ced_decode_t decode_out;
  logic running_out, bus_release_out, refresh_active_out, normal_mode_out, segmented_out;
  logic instr_taken_out, priv_trap_out, ext_trap_out, ext_issue_out, addr_mem_out;
  logic [22:0] addr_out;
  int error_cnt = 0;
  int num_checks = 0;
  assign halt_n_in = hold_n & unit_halt_n;
  ced_exec_front #(.EXT_UNITS(3)) i_dut (.*);
  ced_ext_unit_model i_unit (.clk_in(clk_in), .reset_in(reset_in), .issue_in(ext_issue_out),
    .halt_n_out(unit_halt_n), .busy_out(ext_busy_in));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic load(input logic [15:0] v);
    @(posedge clk_in);
    fcw_load_in <= 1'b1;
    fcw_in <= v;
    @(posedge clk_in);
    fcw_load_in <= 1'b0;
    @(negedge clk_in);
    chk(flag_control_word_out, v);
  endtask
  // res is {privilege trap, extension trap, issue}
  task automatic op(input logic [15:0] w, input logic [15:0] e, input logic [2:0] res);
    @(posedge clk_in);
    instr_valid_in <= 1'b1;
    opnd_in.word <= w;
    opnd_in.ext <= e;
    @(posedge clk_in);
    instr_valid_in <= 1'b0;
    @(negedge clk_in);
    chk({instr_taken_out, priv_trap_out, ext_trap_out, ext_issue_out}, {1'b1, res});
  endtask
  task automatic t_modes;
    load(16'h0000);
    chk({normal_mode_out, segmented_out}, 2'b10);
    @(posedge clk_in);
    in_interrupt_in <= 1'b1;
    @(negedge clk_in);
    chk({normal_mode_out, segmented_out}, 2'b01);
    @(posedge clk_in);
    in_interrupt_in <= 1'b0;
    op(16'h3d00, 16'h0000, 3'b100);
    load(16'h4000);
    op(16'h3d00, 16'h0000, 3'b000);
  endtask
  task automatic t_ext;
    op(16'h8e00, 16'h0000, 3'b010);
    load(16'h4400);
    for (int i = 0; i < 4; i++) begin
      tick(6);
      op(16'h8e00 | 16'(i), 16'h1230 + 16'(i), i < 3 ? 3'b001 : 3'b010);
      if (i < 3) chk({ext_unit_out, ext_word_out}, {2'(i), 16'h1230 + 16'(i)});
    end
    tick(6);
    op(16'h8e00, 16'h0000, 3'b001);
    op(16'h8e00, 16'h0000, 3'b010);
    tick(6);
    op(16'h0e00, 16'h0000, 3'b010);
    @(posedge clk_in);
    ext_units_present_in <= 1'b0;
    op(16'h8e00, 16'h0000, 3'b010);
    @(posedge clk_in);
    ext_units_present_in <= 1'b1;
  endtask
  task automatic t_compact;
    for (int i = 0; i < 4; i++) begin
      op(16'hc000 | 16'(i << 12), 16'h0000, 3'b000);
      chk({decode_out.compact, decode_out.compact_op}, {1'b1, 2'(i)});
    end
    op(16'hb000, 16'h0000, 3'b000);
    chk(decode_out.compact, 1'b0);
  endtask
  task automatic t_addr;
    load(16'h4000);
    op(16'ha000, 16'h0234, 3'b000);
    chk({addr_mem_out, addr_out}, {1'b1, 23'h001234});
    load(16'hc000);
    op(16'ha000, 16'h0234, 3'b000);
    chk(addr_out, {7'h05, 16'h1234});
    op(16'h4000, 16'h0abc, 3'b000);
    chk(addr_out, {7'h05, 16'h0abc});
    op(16'h4010, 16'h0abc, 3'b000);
    chk(addr_out, {7'h05, 16'h0dbc});
    op(16'ha010, 16'h0010, 3'b000);
    chk(addr_out, {7'h05, 16'h2010});
    op(16'hb010, 16'h0000, 3'b000);
    chk(addr_out, {7'h05, 16'h2300});
    op(16'h8012, 16'h0000, 3'b000);
    chk({addr_mem_out, decode_out.amode}, {1'b0, ced_pkg::CED_AM_REG});
    chk({decode_out.src, decode_out.dst}, {4'h1, 4'h2});
  endtask
  // k: 0 bus request, 1 halt pin, 2 refresh due
  task automatic t_susp(input int k);
    @(posedge clk_in);
    bus_req_n_in <= k != 0;
    hold_n <= k != 1;
    refresh_due_in <= k == 2;
    tick(4);
    instr_valid_in <= 1'b1;
    tick(3);
    @(negedge clk_in);
    chk({state_out, bus_release_out, refresh_active_out, instr_taken_out},
      k == 0 ? {ced_pkg::CED_DISC, 3'b100} : {ced_pkg::CED_STOP, 3'b010});
    @(posedge clk_in);
    instr_valid_in <= 1'b0;
    bus_req_n_in <= 1'b1;
    hold_n <= 1'b1;
    refresh_due_in <= 1'b0;
    refresh_done_in <= k == 2;
    @(posedge clk_in);
    refresh_done_in <= 1'b0;
    tick(3);
    @(negedge clk_in);
    chk(state_out, ced_pkg::CED_RUN);
    op(16'ha000, 16'h0111, 3'b000);
    chk(addr_out, {7'h05, 16'h1111});
  endtask
  initial begin
    reset_in = 1'b1;
    hold_n = 1'b1;
    bus_req_n_in = 1'b1;
    refresh_due_in = 1'b0;
    refresh_done_in = 1'b0;
    in_interrupt_in = 1'b0;
    fcw_load_in = 1'b0;
    fcw_in = 16'h0000;
    ext_units_present_in = 1'b1;
    instr_valid_in = 1'b0;
    opnd_in = '0;
    opnd_in.pc = 16'h1000;
    opnd_in.long_address_mode_bit = 7'h05;
    opnd_in.reg_src = 16'h2000;
    opnd_in.reg_idx = 16'h0300;
    tick(20);
    reset_in <= 1'b0;
    @(negedge clk_in);
    chk({state_out, flag_control_word_out, normal_mode_out}, {ced_pkg::CED_RUN, 16'h4000, 1'b0});
    t_modes();
    t_ext();
    t_compact();
    t_addr();
    for (int k = 0; k < 3; k++) t_susp(k);
    complete_run();
  end
  initial begin
    tick(3000);
    error_cnt++;
    complete_run();
  end
endmodule
